// File: rtl/wdog_consts.svh
/*
  Constants for the windowed watchdog: counter width, prescaler ratios,
  reset values and nominal timing figures.
  Assumes inclusion by bare name from the package and design files.
*/
`ifndef WDOG_CONSTS_SVH
`define WDOG_CONSTS_SVH

`define WDOG_CNT_W 16
`define WDOG_PRE_W 14
`define WDOG_DIV_LONG 16384
`define WDOG_DIV_SHORT 256
`define WDOG_RELOAD_RST 16'hFFFC
`define WDOG_WINDOW_RST 16'h0000
`define WDOG_CNT_MAX 16'hFFFF
`define WDOG_WU_FREQ_KHZ 500
`define WDOG_SYS_FREQ_MHZ 80
`define WDOG_CLK_FREQ_MHZ 25

`endif

// File: rtl/wdog_pkg.sv
/*
  Types shared by the watchdog design files.
  Assumes the constants header is on the include path.
*/
`include "wdog_consts.svh"

package wdog_pkg;

  typedef enum logic {
    SRC_SYS,
    SRC_WAKEUP
  } clk_src_t;

  typedef enum logic {
    DIV_LONG,
    DIV_SHORT
  } div_sel_t;

  typedef struct packed {
    logic [`WDOG_CNT_W-1:0] reloadValue;
    logic [`WDOG_CNT_W-1:0] windowBoundary;
    div_sel_t divSel;
    clk_src_t clkSrc;
  } wdog_cfg_t;

  typedef struct packed {
    logic overflow;
    logic early;
  } wdog_cause_t;

endpackage : wdog_pkg

// File: rtl/wdog_prescaler.sv
/*
  Prescaler for the watchdog counter: divides the selected source tick by
  the long or short ratio and emits a one-cycle tick.
  Assumes srcTick is a one-cycle enable synchronous to clk.
*/
`timescale 1ns/1ps
`include "wdog_consts.svh"

module wdog_prescaler #(
  parameter int PRE_W = `WDOG_PRE_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic restart,
  input wire logic srcTick,
  input wire wdog_pkg::div_sel_t divSel,
  // result
  output logic tick
);
  import wdog_pkg::*;

  // the long ratio needs the full width; a narrower count would wrap early
  if ((1 << PRE_W) < `WDOG_DIV_LONG) begin : g_width_check
    $error("prescaler too narrow for the long ratio");
  end

  logic [PRE_W-1:0] count;
  logic [PRE_W-1:0] lastValue;

  // R7
  assign lastValue = (divSel == DIV_SHORT) ?
    PRE_W'(`WDOG_DIV_SHORT - 1) : PRE_W'(`WDOG_DIV_LONG - 1);
  assign tick = run && srcTick && (count >= lastValue);

  always_ff @(posedge clk) begin
    if (rst || restart || !run) begin
      count <= '0;
    end else if (srcTick) begin
      if (count >= lastValue) begin
        count <= '0;
      end else begin
        count <= count + PRE_W'(1);
      end
    end
  end

endmodule : wdog_prescaler

// File: rtl/windowed_watchdog_timer.sv
/*
  Windowed watchdog timer: 16-bit up-counter reloaded on service, with an
  early-service window and a held reset request.
  Assumes the instruction strobes, service strobe and wake-up tick are
  single-cycle pulses synchronous to clk; the reset logic acknowledges.
*/
// Functional notes
// R1 - After every reset the watchdog counts and is armed at once.
// R2 - Disable stops the counter, enable restarts it, accepted any time.
// R3 - Software must service the watchdog before the counter overflows.
// R4 - An overflow of the unserviced counter raises a reset request.
// R5 - A service below the programmable window boundary raises a request.
// R6 - The counter is 16 bits wide and counts upward.
// R7 - The count clock is system or wake-up tick divided by 16384 or 256.
// R8 - The counter is loaded from the software reload value.
// R9 - Each valid service reloads the counter from the reload value.
// R10 - Default timeout after power-up is about 0.13 s at 500 kHz wake-up.
// R11 - At 80 MHz system clock the interval spans 3.2 us to 13.4 s.
// R12 - At 500 kHz wake-up clock the interval spans 512 us to 2147.5 s.
// R13 - The reset request is registered and held until acknowledged.
// R14 - Window and prescaler settings take effect at the next reload.
`timescale 1ns/1ps
`include "wdog_consts.svh"

module windowed_watchdog_timer #(
  parameter int CNT_W = `WDOG_CNT_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // software configuration
  input wire wdog_pkg::wdog_cfg_t cfg,
  // software actions
  input wire logic serviceStrobe,
  input wire logic guard_disable_instruction,
  input wire logic guard_enable_instruction,
  // wake-up oscillator tick
  input wire logic wakeup_osc_clock,
  // reset request to the system reset logic
  input wire logic resetAck,
  output logic resetRequest,
  output wdog_pkg::wdog_cause_t resetCause,
  // status
  output logic running,
  output logic [CNT_W-1:0] count
);
  import wdog_pkg::*;

  if (CNT_W != `WDOG_CNT_W) begin : g_width_check
    $error("counter must be 16 bits");
  end

  logic enabled;
  div_sel_t activeDiv;
  clk_src_t activeSrc;
  logic [CNT_W-1:0] activeWindow;
  logic srcTick;
  logic countTick;
  logic reload;
  logic early;
  logic overflow;

  // R1 R2
  always_ff @(posedge clk) begin
    if (rst) begin
      enabled <= 1'b1;
    end else if (guard_enable_instruction) begin
      enabled <= 1'b1;
    end else if (guard_disable_instruction) begin
      enabled <= 1'b0;
    end
  end
  assign running = enabled;

  // R5: a service while below the boundary is early; R3 binds software
  assign early = enabled && serviceStrobe && (count < activeWindow);
  assign reload = serviceStrobe && !early; // R9

  // R7: source from the system clock itself or the wake-up tick
  assign srcTick = (activeSrc == SRC_SYS) ? 1'b1 : wakeup_osc_clock;

  wdog_prescaler #(
    .PRE_W(`WDOG_PRE_W)
  ) prescaler (
    .clk(clk),
    .rst(rst),
    .run(enabled),
    .restart(reload),
    .srcTick(srcTick),
    .divSel(activeDiv),
    .tick(countTick)
  );

  assign overflow = countTick && (count == `WDOG_CNT_MAX); // R4

  // R6 R8 R9 R11 R12: span is the 16-bit range times the chosen ratio
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= `WDOG_RELOAD_RST;
    end else if (reload || overflow) begin
      count <= cfg.reloadValue;
    end else if (countTick) begin
      count <= count + CNT_W'(1);
    end
  end

  // R14: settings latched only at a reload; R10 default long divide
  always_ff @(posedge clk) begin
    if (rst) begin
      activeDiv <= DIV_LONG;
      activeSrc <= SRC_WAKEUP;
      activeWindow <= `WDOG_WINDOW_RST;
    end else if (reload || overflow) begin
      activeDiv <= cfg.divSel;
      activeSrc <= cfg.clkSrc;
      activeWindow <= cfg.windowBoundary;
    end
  end

  // R13: set wins over acknowledge
  always_ff @(posedge clk) begin
    if (rst) begin
      resetRequest <= 1'b0;
      resetCause <= '0;
    end else if (overflow || early) begin
      resetRequest <= 1'b1;
      resetCause.overflow <= resetCause.overflow | overflow;
      resetCause.early <= resetCause.early | early;
    end else if (resetAck) begin
      resetRequest <= 1'b0;
      resetCause <= '0;
    end
  end

endmodule : windowed_watchdog_timer

// File: verification/wdog_properties.sv
/* Watchdog port checks; assumes one clock and a sync reset. */
`timescale 1ns/1ps
module wdog_properties (
  // watched ports
  input wire logic clk,
  input wire logic rst,
  input wire wdog_pkg::wdog_cfg_t cfg,
  input wire logic serviceStrobe,
  input wire logic resetAck,
  input wire logic resetRequest,
  input wire wdog_pkg::wdog_cause_t resetCause,
  input wire logic running,
  input wire logic [15:0] count
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_ok; serviceStrobe && !resetCause.early ##1 !resetCause.early;
  endsequence
  property p_arm; $past(rst) |-> running && count == 16'hFFFC; endproperty
  property p_stop; !running && !serviceStrobe |=> $stable(count); endproperty
  property p_up; running && !serviceStrobe && ~&count |=> count-$past(count)<2;
  endproperty
  property p_svc; s_ok |-> count == $past(cfg.reloadValue); endproperty
  property p_ovf; $rose(resetCause.overflow) |-> &$past(count); endproperty
  property p_early; $rose(resetCause.early) |-> $past(serviceStrobe);
  endproperty
  property p_hold; resetRequest && !resetAck |=> resetRequest; endproperty
  property p_req; $rose(resetRequest) |-> resetCause != 0; endproperty
  a_arm: assert property (p_arm) else $error("not armed");
  a_stop: assert property (p_stop) else $error("count moved");
  a_up: assert property (p_up) else $error("bad step");
  a_svc: assert property (p_svc) else $error("no reload");
  a_ovf: assert property (p_ovf) else $error("bad overflow");
  a_early: assert property (p_early) else $error("bad early");
  a_hold: assert property (p_hold) else $error("dropped");
  a_req: assert property (p_req) else $error("no cause");
endmodule : wdog_properties
bind windowed_watchdog_timer wdog_properties u_props (.clk, .rst, .cfg,
  .serviceStrobe, .resetAck, .resetRequest, .resetCause, .running, .count);

// File: verification/wdog_reset_logic.sv
/* Reset logic model; acks a held request after 64 cycles. */
`timescale 1ns/1ps
module wdog_reset_logic (
  // handshake
  input wire logic clk,
  input wire logic resetRequest,
  output logic resetAck = 1'b0
);
  logic [5:0] age = 6'h00;
  // slow on purpose, so the request must stand on its own meanwhile
  always_ff @(posedge clk) begin
    age <= resetRequest ? age + 6'h01 : 6'h00;
    resetAck <= &age;
  end
endmodule : wdog_reset_logic

// File: verification/tb_top.sv
/* Watchdog bench; assumes the reset logic model. */
`timescale 1ns/1ps
module tb_top;
  typedef enum {SVC, DIS, EN} strobe_t;
  logic clk = 0, rst = 1, svc = 0, dis = 0, en = 0, wu = 0, ack, req, run;
  wdog_pkg::wdog_cfg_t cfg = '0;
  logic [1:0] cause;
  logic [15:0] cnt;
  int mismatches = 0, compares = 0, cyc = 0;
  always #20 clk = ~clk;
  // wake-up tick every other cycle keeps the long-divide run affordable
  always @(negedge clk) wu <= ~wu;
  always @(negedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 40000) begin
      mismatches++;
      finish_test();
    end
  end
  windowed_watchdog_timer u_windowed_watchdog_timer (.clk, .rst, .cfg,
    .serviceStrobe(svc), .guard_disable_instruction(dis),
    .guard_enable_instruction(en), .wakeup_osc_clock(wu), .resetAck(ack),
    .resetRequest(req), .resetCause(cause), .running(run), .count(cnt));
  wdog_reset_logic u_wdog_reset_logic (.clk, .resetRequest(req),
    .resetAck(ack));
  task check(logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic pulse(strobe_t which);
    case (which)
      SVC: svc = 1;
      DIS: dis = 1;
      default: en = 1;
    endcase
    @(negedge clk);
    svc = 0;
    dis = 0;
    en = 0;
  endtask : pulse
  task finish_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task t_count;
    check(run, 1);
    check(cnt, 16'hFFFC);
    cfg = {16'hFFFD, 16'h0000, 2'b10};
    pulse(SVC);
    check(cnt, 16'hFFFD);
    repeat (250) @(negedge clk);
    check(cnt, 16'hFFFD);
    repeat (12) @(negedge clk);
    check(cnt, 16'hFFFE);
    repeat (900) if (!req) @(negedge clk);
    check(cause, 2'b10);
    repeat (80) @(negedge clk);
    check(req, 0);
  endtask : t_count
  // wake-up source with the long ratio: one tick is 16384 wake-up ticks
  task t_wake;
    cfg = {16'hFFFF, 16'h0000, 2'b01};
    pulse(SVC);
    repeat (32760) @(negedge clk);
    check(req, 0);
    repeat (16) @(negedge clk);
    check(cause, 2'b10);
    check(cnt, 16'hFFFF);
    repeat (80) @(negedge clk);
  endtask : t_wake
  task t_win;
    cfg = {16'h0010, 16'h0000, 2'b10};
    pulse(SVC);
    cfg = {16'h0020, 16'h0100, 2'b10};
    @(negedge clk) pulse(SVC);
    @(negedge clk) check(req, 0);
    cfg.reloadValue = 16'h0030;
    pulse(SVC);
    check(cause, 2'b01);
    check(cnt, 16'h0020);
    repeat (80) @(negedge clk);
  endtask : t_win
  task t_dis;
    pulse(DIS);
    repeat (300) @(negedge clk);
    check(run, 0);
    check(cnt, 16'h0020);
    pulse(EN);
    check(run, 1);
  endtask : t_dis
  initial begin
    repeat (4) @(negedge clk);
    rst = 0;
    t_count();
    t_wake();
    t_win();
    t_dis();
    finish_test();
  end
endmodule : tb_top
